//--- src/fmx_pkg.sv
// fmx_pkg: constants, types and helpers shared by the field move and branch executor
package fmx_pkg;
   // =====================================================
   // function codes
   localparam logic [4:0] FMX_F_MOVE = 5'h08;
   localparam logic [4:0] FMX_F_NUM = 5'h09;
   localparam logic [4:0] FMX_F_BRANCH = 5'h0b;
   localparam logic [4:0] FMX_F_XCHG = 5'h0f;
   // =====================================================
   // register byte offsets
   localparam logic [3:0] FMX_REG_CMD = 4'h0;
   localparam logic [3:0] FMX_REG_ADDR = 4'h4;
   localparam logic [3:0] FMX_REG_PCNT = 4'h8;
   localparam logic [3:0] FMX_REG_STAT = 4'hc;
   // register field positions
   localparam int FMX_CMD_FUNC_LSB = 0;
   localparam int FMX_CMD_TENS_LSB = 8;
   localparam int FMX_CMD_UNITS_LSB = 12;
   localparam int FMX_CMD_BUSY_BIT = 31;
   localparam int FMX_ADDR_B_LSB = 16;
   localparam int FMX_PCNT_EXTRA_BIT = 16;
   // =====================================================
   // reset values and counts
   localparam logic [15:0] FMX_PTR_RST = 16'h0000;
   localparam logic [5:0] FMX_CHAR_RST = 6'h00;
   localparam logic [6:0] FMX_LEN_FULL = 7'h64; // length 00 means 100
   localparam logic [3:0] FMX_HALF_LAST = 4'h4; // last char of first half
   localparam logic [3:0] FMX_FULL_LAST = 4'h9; // last char of second half
   localparam logic [1:0] FMX_STORE_LAST = 2'h3; // four counter digits
   // =====================================================
   // variants
   localparam logic [3:0] FMX_V_STORE = 4'h6;
   localparam logic [3:0] FMX_V_SREQ = 4'h7;
   localparam logic [3:0] FMX_V_SWITCH = 4'h8;
   typedef enum logic [3:0] {
      FMX_S_IDLE, FMX_S_RD_DST, FMX_S_RD_SRC, FMX_S_WR_DST, FMX_S_WR_SRC, FMX_S_STEP,
      FMX_S_FETCH, FMX_S_HALF, FMX_S_ST_RD, FMX_S_ST_WR, FMX_S_SV_RD, FMX_S_SV_WR,
      FMX_S_LOAD
   } fmx_state_t;
   // four-digit decimal increment, wraps at 9999
   function automatic logic [15:0] fmx_bcd_inc(input logic [15:0] v);
      logic [15:0] r;
      logic c;
      r = v;
      c = 1'b1;
      for (int i = 0; i < 4; i++)
      begin
         if (c)
         begin
            if (r[i*4 +: 4] == 4'h9)
               r[i*4 +: 4] = 4'h0;
            else
            begin
               r[i*4 +: 4] = r[i*4 +: 4] + 4'h1;
               c = 1'b0;
            end
         end
      end
      return r;
   endfunction
endpackage

//--- src/fmx_flag_if.sv
// fmx_flag_if: synchronised condition and peripheral status carried inside the block
`timescale 1ns/1ns
interface fmx_flag_if;
   logic zero;
   logic minus;
   logic carry;
   logic sreq;
   logic timeout;
   logic [3:0] io_id;
   modport prod (output zero, minus, carry, sreq, timeout, io_id);
   modport cons (input zero, minus, carry, sreq, timeout, io_id);
endinterface

//--- src/fmx_flag_sync.sv
// fmx_flag_sync: two-stage synchronisers for all status pins
`timescale 1ns/1ns
module fmx_flag_sync
   import fmx_pkg::*;
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // raw pins
   input wire logic [8:0] pins,
   // synchronised side
   fmx_flag_if.prod flg
);
   logic [8:0] meta;
   logic [8:0] stable;
   // =====================================================
   // first stage read only by the second
   genvar g;
   generate
      for (g = 0; g < 9; g++)
      begin : g_sync
         always_ff @(posedge sys_clk or posedge rst)
         begin
            if (rst)
            begin
               meta[g] <= 1'b0;
               stable[g] <= 1'b0;
            end
            else
            begin
               meta[g] <= pins[g];
               stable[g] <= meta[g];
            end
         end
      end
   endgenerate
   assign flg.zero = stable[0];
   assign flg.minus = stable[1];
   assign flg.carry = stable[2];
   assign flg.sreq = stable[3];
   assign flg.timeout = stable[4];
   assign flg.io_id = stable[8:5];
endmodule // fmx_flag_sync

//--- src/fmx_branch_qual.sv
// fmx_branch_qual: compares a branch variant against the condition flags
`timescale 1ns/1ns
module fmx_branch_qual
   import fmx_pkg::*;
(
   // variant and flags
   input wire logic [3:0] variant,
   fmx_flag_if.cons flg,
   // verdict
   output logic branch_qualified
);
   // =====================================================
   // 6, 7, 0, 9 and unused codes never qualify here
   always_comb
   begin
      unique case (variant)
         4'h1: branch_qualified = !flg.zero && flg.minus;
         4'h2: branch_qualified = flg.zero;
         4'h3: branch_qualified = !flg.zero && !flg.minus;
         4'h4: branch_qualified = flg.carry;
         4'h5, 4'h8: branch_qualified = 1'b1;
         default: branch_qualified = 1'b0;
      endcase
   end
endmodule // fmx_branch_qual

//--- src/fmx_exec.sv
// fmx_exec: field move, numeric move, exchange and branch execution sequencer
//
// The Avalon-MM slave port and the register offsets were decided locally.
`timescale 1ns/1ns
module fmx_exec
   import fmx_pkg::*;
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // avalon-mm slave
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // main memory character port
   output logic [15:0] mem_addr,
   output logic mem_rd,
   output logic mem_wr,
   output logic [5:0] mem_wdata,
   input wire logic [5:0] mem_rdata,
   input wire logic mem_ack,
   // condition flags and io controller status (pins)
   input wire logic flag_zero,
   input wire logic flag_minus,
   input wire logic flag_carry,
   input wire logic timeout_pending,
   input wire logic service_request,
   input wire logic [3:0] io_id,
   // sequence outcome pulses
   output logic exec_done,
   output logic goto_switch,
   output logic goto_begin
);
   fmx_flag_if flg ();
   fmx_state_t state;
   logic [4:0] func;
   logic [3:0] len_tens;
   logic [3:0] len_units;
   logic [15:0] a_ptr;
   logic [15:0] b_ptr;
   logic [15:0] cfg_a;
   logic [15:0] cfg_b;
   logic [6:0] len;
   logic [5:0] dchar; // destination stash
   logic [5:0] schar; // source latch
   logic [15:0] p_cnt;
   logic counter_extra_bit;
   logic [3:0] length_field_a;
   logic [3:0] length_field_b;
   logic [3:0] var_hold;
   logic [11:0] addr_sh;
   logic [3:0] fidx;
   logic [1:0] store_idx;
   logic start;
   logic last_taken;
   logic last_switch;
   logic bad_func;
   logic branch_qualified;
   logic ack;
   logic need_rd;
   logic need_wr;
   logic [15:0] next_addr;
   logic [5:0] next_wdata;
   logic [3:0] p_digit;
   logic [6:0] len_init;
   logic [15:0] new_addr;
   logic is_move;
   logic bus_wr;
   logic final_taken;
   // =====================================================
   // submodules
   fmx_flag_sync u_sync (
      .sys_clk(sys_clk),
      .rst(rst),
      .pins({io_id, timeout_pending, service_request, flag_carry, flag_minus, flag_zero}),
      .flg(flg)
   );
   fmx_branch_qual u_qual (
      .variant(length_field_b),
      .flg(flg),
      .branch_qualified(branch_qualified)
   );
   // =====================================================
   // helpers
   assign ack = mem_ack && (mem_rd || mem_wr);
   assign is_move = (func == FMX_F_MOVE) || (func == FMX_F_NUM) || (func == FMX_F_XCHG);
   assign len_init = (len_tens == 4'h0 && len_units == 4'h0) ? FMX_LEN_FULL :
      7'(7'(len_tens) * 7'd10 + 7'(len_units));
   assign new_addr = {addr_sh, mem_rdata[3:0]}; // zone marks ignored: no indexing
   assign bus_wr = avs_write && !avs_waitrequest;
   // service form may also branch on its ordinary variant test
   assign final_taken = branch_qualified || (length_field_a == FMX_V_SREQ && flg.sreq);
   // counter digit for the store form, MSD first
   always_comb
   begin
      unique case (store_idx)
         2'd0: p_digit = p_cnt[15:12];
         2'd1: p_digit = p_cnt[11:8];
         2'd2: p_digit = p_cnt[7:4];
         2'd3: p_digit = p_cnt[3:0];
      endcase
   end
   // =====================================================
   // memory access selection per state
   always_comb
   begin
      need_rd = 1'b0;
      need_wr = 1'b0;
      next_addr = b_ptr;
      next_wdata = schar;
      unique case (state)
         FMX_S_RD_DST: need_rd = 1'b1;
         FMX_S_RD_SRC:
         begin
            need_rd = 1'b1;
            next_addr = a_ptr;
         end
         FMX_S_WR_DST:
         begin
            need_wr = 1'b1;
            if (func == FMX_F_NUM)
               next_wdata = {dchar[5:4], schar[3:0]};
         end
         FMX_S_WR_SRC:
         begin
            need_wr = 1'b1;
            next_addr = a_ptr;
            next_wdata = dchar;
         end
         FMX_S_FETCH:
         begin
            need_rd = 1'b1;
            next_addr = p_cnt;
         end
         FMX_S_ST_RD, FMX_S_SV_RD:
         begin
            need_rd = 1'b1;
            next_addr = a_ptr;
         end
         FMX_S_ST_WR:
         begin
            need_wr = 1'b1;
            next_addr = a_ptr;
            if (store_idx == FMX_STORE_LAST)
               next_wdata = {counter_extra_bit, 1'b1, p_digit};
            else
               next_wdata = {dchar[5:4], p_digit};
         end
         FMX_S_SV_WR:
         begin
            need_wr = 1'b1;
            next_addr = a_ptr;
            next_wdata = {dchar[5:4], flg.io_id};
         end
         default: ;
      endcase
   end
   // =====================================================
   // memory port: a new access only once the last one is acknowledged
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         mem_rd <= 1'b0;
         mem_wr <= 1'b0;
         mem_addr <= FMX_PTR_RST;
         mem_wdata <= FMX_CHAR_RST;
      end
      else if (mem_rd || mem_wr)
      begin
         if (mem_ack)
         begin
            mem_rd <= 1'b0;
            mem_wr <= 1'b0;
         end
      end
      else if (need_rd || need_wr)
      begin
         mem_rd <= need_rd;
         mem_wr <= need_wr;
         mem_addr <= next_addr;
         mem_wdata <= next_wdata;
      end
   end
   // =====================================================
   // sequencer
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
         state <= FMX_S_IDLE;
      else
      begin
         unique case (state)
            FMX_S_IDLE:
               if (start && func == FMX_F_BRANCH)
                  state <= FMX_S_FETCH;
               else if (start && is_move)
                  state <= (func == FMX_F_MOVE) ? FMX_S_RD_SRC : FMX_S_RD_DST;
            FMX_S_RD_DST: if (ack) state <= FMX_S_RD_SRC;
            FMX_S_RD_SRC: if (ack) state <= FMX_S_WR_DST;
            FMX_S_WR_DST:
               if (ack)
                  state <= (func == FMX_F_XCHG) ? FMX_S_WR_SRC : FMX_S_STEP;
            FMX_S_WR_SRC: if (ack) state <= FMX_S_STEP;
            FMX_S_STEP:
               if (len == 7'd1)
                  state <= FMX_S_IDLE;
               else
                  state <= (func == FMX_F_MOVE) ? FMX_S_RD_SRC : FMX_S_RD_DST;
            FMX_S_FETCH:
               if (ack && (fidx == FMX_HALF_LAST || fidx == FMX_FULL_LAST))
                  state <= FMX_S_HALF;
            FMX_S_HALF:
               if (fidx == FMX_HALF_LAST + 4'h1)
               begin
                  // ten-char forms never branch on the first half
                  if (length_field_a == FMX_V_STORE || length_field_a == FMX_V_SREQ)
                     state <= FMX_S_FETCH;
                  else if (branch_qualified)
                     state <= FMX_S_LOAD;
                  else
                     state <= FMX_S_FETCH;
               end
               else if (!final_taken)
                  state <= FMX_S_IDLE;
               else if (length_field_a == FMX_V_STORE)
                  state <= FMX_S_ST_RD;
               else if (length_field_a == FMX_V_SREQ)
                  state <= FMX_S_SV_RD;
               else
                  state <= FMX_S_LOAD;
            FMX_S_ST_RD: if (ack) state <= FMX_S_ST_WR;
            FMX_S_ST_WR:
               if (ack)
                  state <= (store_idx == FMX_STORE_LAST) ? FMX_S_LOAD : FMX_S_ST_RD;
            FMX_S_SV_RD: if (ack) state <= FMX_S_SV_WR;
            FMX_S_SV_WR: if (ack) state <= FMX_S_LOAD;
            FMX_S_LOAD: state <= FMX_S_IDLE;
         endcase
      end
   end
   // =====================================================
   // move datapath: length, stash, latch and store digit index
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         len <= 7'd0;
         dchar <= FMX_CHAR_RST;
         schar <= FMX_CHAR_RST;
         store_idx <= 2'd0;
      end
      else
      begin
         if (state == FMX_S_IDLE && start)
            len <= len_init;
         if (state == FMX_S_STEP)
            len <= len - 7'd1;
         if ((state == FMX_S_RD_DST || state == FMX_S_ST_RD || state == FMX_S_SV_RD) && ack)
            dchar <= mem_rdata;
         if (state == FMX_S_RD_SRC && ack)
            schar <= mem_rdata;
         if (state == FMX_S_HALF)
            store_idx <= 2'd0;
         else if (state == FMX_S_ST_WR && ack)
            store_idx <= store_idx + 2'd1;
      end
   end
   // =====================================================
   // pointers: loaded by start or branch halves, stepped by moves
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         a_ptr <= FMX_PTR_RST;
         b_ptr <= FMX_PTR_RST;
      end
      else if (state == FMX_S_IDLE && start)
      begin
         a_ptr <= cfg_a;
         b_ptr <= cfg_b;
      end
      else if (state == FMX_S_STEP)
      begin
         a_ptr <= fmx_bcd_inc(a_ptr);
         b_ptr <= fmx_bcd_inc(b_ptr);
      end
      else if (state == FMX_S_ST_WR && ack)
         a_ptr <= fmx_bcd_inc(a_ptr);
      else if (state == FMX_S_FETCH && ack && fidx == FMX_HALF_LAST)
      begin
         a_ptr <= new_addr;
         b_ptr <= new_addr;
      end
      else if (state == FMX_S_FETCH && ack && fidx == FMX_FULL_LAST)
         b_ptr <= new_addr;
   end
   // =====================================================
   // branch fetch: variant digit then four address digits per half
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         fidx <= 4'h0;
         var_hold <= 4'h0;
         addr_sh <= 12'h000;
         length_field_a <= 4'h0;
         length_field_b <= 4'h0;
      end
      else if (state == FMX_S_IDLE)
         fidx <= 4'h0;
      else if (state == FMX_S_FETCH && ack)
      begin
         fidx <= fidx + 4'h1;
         if (fidx == 4'h0 || fidx == FMX_HALF_LAST + 4'h1)
            var_hold <= mem_rdata[3:0];
         else
            addr_sh <= {addr_sh[7:0], mem_rdata[3:0]};
         if (fidx == FMX_HALF_LAST)
         begin
            length_field_a <= var_hold;
            length_field_b <= var_hold;
         end
         else if (fidx == FMX_FULL_LAST)
            length_field_b <= var_hold;
      end
   end
   // =====================================================
   // instruction counter: steps per fetched char, low digit cleared on branch
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         p_cnt <= FMX_PTR_RST;
         counter_extra_bit <= 1'b0;
      end
      else if (state == FMX_S_FETCH && ack)
         p_cnt <= fmx_bcd_inc(p_cnt);
      else if (state == FMX_S_LOAD)
         p_cnt <= {b_ptr[15:4], 4'h0};
      else if (state == FMX_S_IDLE && bus_wr && avs_address == FMX_REG_PCNT)
      begin
         p_cnt <= avs_writedata[15:0];
         counter_extra_bit <= avs_writedata[FMX_PCNT_EXTRA_BIT];
      end
   end
   // =====================================================
   // outcome pulses and sticky status; flags are only ever read
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         exec_done <= 1'b0;
         goto_switch <= 1'b0;
         goto_begin <= 1'b0;
         last_taken <= 1'b0;
         last_switch <= 1'b0;
         bad_func <= 1'b0;
      end
      else
      begin
         exec_done <= 1'b0;
         goto_switch <= 1'b0;
         goto_begin <= 1'b0;
         if (state == FMX_S_IDLE && start)
         begin
            bad_func <= !is_move && func != FMX_F_BRANCH;
            exec_done <= !is_move && func != FMX_F_BRANCH;
         end
         if (state == FMX_S_STEP && len == 7'd1)
            exec_done <= 1'b1;
         if (state == FMX_S_HALF && fidx != FMX_HALF_LAST + 4'h1 && !final_taken)
         begin
            exec_done <= 1'b1;
            goto_begin <= 1'b1;
            last_taken <= 1'b0;
            last_switch <= 1'b0;
         end
         if (state == FMX_S_LOAD)
         begin
            exec_done <= 1'b1;
            last_taken <= 1'b1;
            // switch on variant 8 or a pending timeout
            if (length_field_b == FMX_V_SWITCH || flg.timeout)
            begin
               goto_switch <= 1'b1;
               last_switch <= 1'b1;
            end
            else
            begin
               goto_begin <= 1'b1;
               last_switch <= 1'b0;
            end
         end
      end
   end
   // =====================================================
   // command and address registers, written only while idle
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         func <= 5'h00;
         len_tens <= 4'h0;
         len_units <= 4'h0;
         cfg_a <= FMX_PTR_RST;
         cfg_b <= FMX_PTR_RST;
         start <= 1'b0;
      end
      else
      begin
         start <= 1'b0;
         if (bus_wr && state == FMX_S_IDLE && !start)
         begin
            if (avs_address == FMX_REG_CMD)
            begin
               func <= avs_writedata[FMX_CMD_FUNC_LSB +: 5];
               len_tens <= avs_writedata[FMX_CMD_TENS_LSB +: 4];
               len_units <= avs_writedata[FMX_CMD_UNITS_LSB +: 4];
               start <= 1'b1;
            end
            if (avs_address == FMX_REG_ADDR)
            begin
               cfg_a <= avs_writedata[15:0];
               cfg_b <= avs_writedata[FMX_ADDR_B_LSB +: 16];
            end
         end
      end
   end
   // =====================================================
   // bus slave: one wait state, data valid as waitrequest drops
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         avs_waitrequest <= 1'b1;
         avs_readdata <= 32'h00000000;
      end
      else if ((avs_read || avs_write) && avs_waitrequest)
      begin
         avs_waitrequest <= 1'b0;
         avs_readdata <= 32'h00000000;
         if (avs_read)
         begin
            unique case (avs_address)
               FMX_REG_CMD: avs_readdata <= {(state != FMX_S_IDLE || start), 15'h0000,
                  len_units, len_tens, 3'h0, func};
               FMX_REG_ADDR: avs_readdata <= {cfg_b, cfg_a};
               FMX_REG_PCNT: avs_readdata <= {15'h0000, counter_extra_bit, p_cnt};
               FMX_REG_STAT: avs_readdata <= {28'h0000000, bad_func, last_switch, last_taken,
                  (state != FMX_S_IDLE || start)};
               default: avs_readdata <= 32'h00000000;
            endcase
         end
      end
      else
         avs_waitrequest <= 1'b1;
   end
endmodule // fmx_exec

//--- dv/fmx_mem_model.sv
// fmx_mem_model: character main memory answering the executor's port
`timescale 1ns/1ns
module fmx_mem_model
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // character port
   input wire logic [15:0] mem_addr,
   input wire logic mem_rd,
   input wire logic mem_wr,
   input wire logic [5:0] mem_wdata,
   output logic [5:0] mem_rdata,
   output logic mem_ack
);
   logic [5:0] m [65536]; // zones in [5:4], numerics in [3:0]
   logic slow;
   logic [1:0] w;
   int rd_cnt = 0;
   int wr_cnt = 0;
   // =====================================
   // one answer per access, every other one after two wait cycles
   always @(posedge sys_clk or posedge rst)
      if (rst)
      begin
         mem_ack <= 1'b0;
         mem_rdata <= 6'h00;
         slow <= 1'b0;
         w <= 2'h0;
      end
      else
      begin
         mem_ack <= 1'b0;
         mem_rdata <= ~mem_rdata; // never stale outside an answer
         if (mem_ack || !(mem_rd || mem_wr))
            w <= 2'h0;
         else if (slow && w != 2'h2)
            w <= w + 2'h1;
         else
         begin
            mem_ack <= 1'b1;
            slow <= ~slow;
            rd_cnt <= rd_cnt + int'(mem_rd);
            wr_cnt <= wr_cnt + int'(mem_wr);
            if (mem_wr)
               m[mem_addr] <= mem_wdata;
            else
               mem_rdata <= m[mem_addr];
         end
      end
endmodule // fmx_mem_model

//--- dv/fmx_exec_checker.sv
// fmx_exec_checker: port assertions for the move and branch executor
`timescale 1ns/1ns
module fmx_exec_checker
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // register bus
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic avs_waitrequest,
   // memory port
   input wire logic [15:0] mem_addr,
   input wire logic mem_rd,
   input wire logic mem_wr,
   input wire logic [5:0] mem_wdata,
   input wire logic mem_ack,
   // outcome pulses
   input wire logic exec_done,
   input wire logic goto_switch,
   input wire logic goto_begin
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   // =====================================
   // memory port: one access, held until its answer, then dropped
   property p_one_access; !(mem_rd && mem_wr); endproperty
   a_one_access: assert property (p_one_access) else $error("read and write together");
   property p_rd_hold; mem_rd && !mem_ack |=> mem_rd && $stable(mem_addr); endproperty
   a_rd_hold: assert property (p_rd_hold) else $error("read not held");
   property p_wr_hold; mem_wr && !mem_ack |=> mem_wr && $stable({mem_addr, mem_wdata}); endproperty
   a_wr_hold: assert property (p_wr_hold) else $error("write not held");
   property p_drop; (mem_rd || mem_wr) && mem_ack |=> !mem_rd && !mem_wr; endproperty
   a_drop: assert property (p_drop) else $error("request kept after answer");
   // =====================================
   // register bus answer and outcome pulses
   property p_answer; (avs_read || avs_write) && avs_waitrequest |-> ##[1:2] !avs_waitrequest; endproperty
   a_answer: assert property (p_answer) else $error("bus not answered");
   property p_wait_one; !avs_waitrequest |=> avs_waitrequest; endproperty
   a_wait_one: assert property (p_wait_one) else $error("answer longer than a cycle");
   property p_goto_done; goto_switch || goto_begin |-> exec_done; endproperty
   a_goto_done: assert property (p_goto_done) else $error("exit without done");
   property p_goto_excl; !(goto_switch && goto_begin); endproperty
   a_goto_excl: assert property (p_goto_excl) else $error("two exits at once");
endmodule // fmx_exec_checker
bind fmx_exec fmx_exec_checker fmx_exec_checker_i (.sys_clk(sys_clk), .rst(rst),
   .avs_read(avs_read), .avs_write(avs_write), .avs_waitrequest(avs_waitrequest),
   .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_wdata(mem_wdata),
   .mem_ack(mem_ack), .exec_done(exec_done), .goto_switch(goto_switch), .goto_begin(goto_begin));

//--- dv/testbench.sv
// testbench: moves and branches over the register bus against a memory model
`timescale 1ns/1ns
module testbench;
   import fmx_pkg::*;
   logic sys_clk = 1'b0, rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0, avs_waitrequest, mem_rd;
   logic flag_zero = 1'b0, flag_minus = 1'b0, flag_carry = 1'b0, timeout_pending = 1'b0;
   logic service_request = 1'b0, mem_wr, mem_ack, exec_done, goto_switch, goto_begin;
   logic [3:0] avs_address = 4'h0, io_id = 4'h0;
   logic [31:0] avs_writedata = 32'h0, avs_readdata, q, g;
   logic [15:0] mem_addr;
   logic [5:0] mem_wdata, mem_rdata;
   logic [4:0] fn [3] = '{FMX_F_MOVE, FMX_F_NUM, FMX_F_XCHG};
   logic [7:0] tbl [12] = '{8'h15, 8'h1c, 8'h29, 8'h26, 8'h31, 8'h34, 8'h43, 8'h4c, 8'h5f,
      8'h81, 8'h0e, 8'h90}; // variant, zero, minus, carry, taken
   int err_total = 0, compares = 0, r0, w0, n;
   fmx_exec fmx_exec_i (.sys_clk(sys_clk), .rst(rst), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .mem_addr(mem_addr),
      .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
      .mem_ack(mem_ack), .flag_zero(flag_zero), .flag_minus(flag_minus),
      .flag_carry(flag_carry), .timeout_pending(timeout_pending),
      .service_request(service_request), .io_id(io_id), .exec_done(exec_done),
      .goto_switch(goto_switch), .goto_begin(goto_begin));
   fmx_mem_model mdl (.sys_clk(sys_clk), .rst(rst), .mem_addr(mem_addr), .mem_rd(mem_rd),
      .mem_wr(mem_wr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_ack(mem_ack));
   // =====================================
   // clock, comparison and bus tasks
   initial
      forever #5 sys_clk = ~sys_clk;
   task automatic test_done;
      $display("compares %0d err_total %0d", compares, err_total);
      if (err_total == 0 && compares > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp)
      begin
         err_total++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // request held until waitrequest is sampled low
   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      {avs_write, avs_read, avs_address, avs_writedata} <= {wr, !wr, a, d};
      do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
      q = avs_readdata;
      {avs_write, avs_read} <= 2'b00;
   endtask
   task automatic run(input logic [31:0] cmd);
      bus(1'b1, FMX_REG_CMD, cmd);
      n = 0;
      do @(posedge sys_clk); while (exec_done !== 1'b1 && ++n < 500);
      g = {30'h0, goto_switch, goto_begin};
      if (n >= 500) err_total++;
   endtask
   // ten-char branch at 0100: first address 1237, second 4565
   task automatic br(input logic [3:0] v1, input logic [3:0] v2, input logic [4:0] f,
      input logic [15:0] cnt, input logic [2:0] st);
      {flag_zero, flag_minus, flag_carry, timeout_pending, service_request} <= f;
      for (int i = 0; i < 10; i++)
         mdl.m[16'h0100 + i] = {2'b00, 4'({v1, 16'h1237, v2, 16'h4565} >> (36 - 4 * i))};
      bus(1'b1, FMX_REG_PCNT, 32'h0000_0100);
      run({27'h0, FMX_F_BRANCH});
      bus(1'b0, FMX_REG_PCNT, 32'h0);
      chk("counter", q, {16'h0, cnt});
      bus(1'b0, FMX_REG_STAT, 32'h0);
      chk("status", q, {29'h0, st});
      chk("exit", g, st[2] ? 32'h2 : 32'h1);
   endtask
   // =====================================
   // test sequence
   initial
   begin
      repeat (16) @(posedge sys_clk);
      rst <= 1'b0;
      foreach (fn[j])
      begin
         for (int k = 0; k < 4; k++)
            {mdl.m[16'h0010 + k], mdl.m[16'h0030 + k]} = {6'(17 + k), 6'(37 + k)};
         bus(1'b1, FMX_REG_ADDR, 32'h0030_0010);
         {r0, w0} = {mdl.rd_cnt, mdl.wr_cnt};
         run({16'h0, 4'h3, 4'h0, 3'h0, fn[j]});
         for (int k = 0; k < 4; k++)
         begin
            chk("dest", 32'(mdl.m[16'h0030 + k]), k == 3 ? 37 + k : j == 1 ? 33 + k : 17 + k);
            chk("source", 32'(mdl.m[16'h0010 + k]), j == 2 && k < 3 ? 37 + k : 17 + k);
         end
         chk("reads", 32'(mdl.rd_cnt - r0), j == 0 ? 3 : 6);
         chk("writes", 32'(mdl.wr_cnt - w0), j == 2 ? 6 : 3);
      end
      foreach (tbl[k])
         br(tbl[k][7:4], 4'h0, {tbl[k][3:1], 2'b00}, tbl[k][0] ? 16'h1230 : 16'h0110,
            {tbl[k][7:4] == 4'h8 && tbl[k][0], tbl[k][0], 1'b0});
      br(4'h0, 4'h2, 5'h10, 16'h4560, 3'h2);
      br(4'h5, 4'h0, 5'h02, 16'h1230, 3'h6);
      br(4'h0, 4'h7, 5'h01, 16'h0110, 3'h0);
      br(4'h0, 4'h6, 5'h01, 16'h0110, 3'h0);
      mdl.m[16'h1237] = 6'h3f;
      br(4'h6, 4'h3, 5'h10, 16'h0110, 3'h0);
      chk("unqualified store", 32'(mdl.m[16'h1237]), 'h3f);
      for (int k = 0; k < 4; k++)
         mdl.m[k < 3 ? 16'h1237 + k : 16'h1240] = 6'h30;
      br(4'h6, 4'h5, 5'h00, 16'h4560, 3'h2);
      for (int k = 0; k < 4; k++)
         chk("stored", 32'(mdl.m[k < 3 ? 16'h1237 + k : 16'h1240]), k == 3 ? 'h10 : 48 + (k % 3 > 0));
      mdl.m[16'h1237] = 6'h20;
      io_id <= 4'h5;
      br(4'h7, 4'h0, 5'h01, 16'h4560, 3'h2);
      chk("requester", 32'(mdl.m[16'h1237]), 'h25);
      br(4'h7, 4'h9, 5'h00, 16'h0110, 3'h0);
      test_done;
   end
   // hang guard
   initial
   begin
      #200000;
      err_total++;
      test_done;
   end
endmodule // testbench
